// [design/timer_channel_capture_compare.sv]
// Capture/compare logic for timer channels 0 and 1 with an AXI4-Lite slave.
// Assumes the counter, its tick strobe, direction and mode come from logic
// on CLK; capture pins are asynchronous; the radio event is on CLK.
`include "tcc_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module timer_channel_capture_compare (
  // Clock and reset
  input  wire logic                    CLK,
  input  wire logic                    NRST,
  // AXI4-Lite write address and data
  input  wire logic [`TCC_ADDR_W-1:0]  AWADDR,
  input  wire logic                    AWVALID,
  output logic                         AWREADY,
  input  wire logic [31:0]             WDATA,
  input  wire logic [3:0]              WSTRB,
  input  wire logic                    WVALID,
  output logic                         WREADY,
  // AXI4-Lite write response
  output logic [1:0]                   BRESP,
  output logic                         BVALID,
  input  wire logic                    BREADY,
  // AXI4-Lite read
  input  wire logic [`TCC_ADDR_W-1:0]  ARADDR,
  input  wire logic                    ARVALID,
  output logic                         ARREADY,
  output logic [31:0]                  RDATA,
  output logic [1:0]                   RRESP,
  output logic                         RVALID,
  input  wire logic                    RREADY,
  // Counter view
  input  wire logic [15:0]             TIMER_COUNT,
  input  wire logic                    COUNT_TICK,
  input  wire logic                    COUNT_DOWN,
  input  wire logic [1:0]              COUNT_MODE,
  // Capture sources
  input  wire logic [1:0]              CAP_IN,
  input  wire logic                    RADIO_IRQ,
  // Compare outputs and interrupt
  output logic [1:0]                   CMP_OUT,
  output logic [1:0]                   CMP_OE,
  output logic                         IRQ
);

  localparam tcc_pkg::state_s ST_RST = '{
    ctl: {`TCC_CTL_RST, `TCC_CTL_RST}, mask: `TCC_MASK_RST, default: '0};

  tcc_pkg::state_s s;
  tcc_pkg::state_s n;

  logic [1:0]  match;
  logic [1:0]  cap_ev;
  logic [1:0]  cmp_ev;
  logic [1:0]  wr_ctl;
  logic [1:0]  wr_lo;
  logic [1:0]  wr_hi;
  logic [1:0]  im;
  logic        do_wr;
  logic        wr_en;
  logic        zero;

  // Index decode shared by read and write paths
  function automatic logic idx_hit(input logic [9:0] idx);
    idx_hit = (idx == `TCC_IDX_CH0_LO) || (idx == `TCC_IDX_CH0_HI) ||
              (idx == `TCC_IDX_CH1_LO) || (idx == `TCC_IDX_CH1_HI) ||
              (idx == `TCC_IDX_CTL0)   || (idx == `TCC_IDX_CTL1)   ||
              (idx == `TCC_IDX_STAT)   || (idx == `TCC_IDX_MASK);
  endfunction : idx_hit

  // Handshakes come straight from the state so the master sees them early
  assign AWREADY = !s.aw_got && !s.bvalid;
  assign WREADY  = !s.w_got && !s.bvalid;
  assign BVALID  = s.bvalid;
  assign BRESP   = s.bresp;
  assign ARREADY = !s.rvalid;
  assign RVALID  = s.rvalid;
  assign RRESP   = s.rresp;
  assign RDATA   = {24'h000000, s.rdata};
  assign CMP_OUT = s.out;
  assign im      = {s.ctl[1][`TCC_IM_BIT], s.ctl[0][`TCC_IM_BIT]};
  assign CMP_OE  = {s.ctl[1][`TCC_MODE_BIT], s.ctl[0][`TCC_MODE_BIT]};
  // Level request while any enabled, unmasked flag stands
  assign IRQ     = |(s.stat & s.mask & im);

  // Next-state logic for bus, channels and flags
  always_comb begin
    logic        src;
    logic        rise;
    logic        fall;
    logic        ud;
    logic        o;
    logic [9:0]  ridx;
    n      = s;
    match  = '0;
    cap_ev = '0;
    cmp_ev = '0;
    wr_ctl = '0;
    wr_lo  = '0;
    wr_hi  = '0;
    src    = 1'b0;
    rise   = 1'b0;
    fall   = 1'b0;
    o      = 1'b0;
    ud     = (COUNT_MODE == `TCC_MODE_UPDOWN);
    zero   = COUNT_TICK && (TIMER_COUNT == `TCC_ZERO);
    ridx   = ARADDR[`TCC_IDX_HI:`TCC_IDX_LO];

    // Pin synchronisers, first stage feeds only the second
    n.sync1 = CAP_IN;
    n.sync2 = s.sync1;

    // Write channel: address and data taken in either order
    if (AWVALID && AWREADY) begin
      n.aw_got = 1'b1;
      n.awidx  = AWADDR[`TCC_IDX_HI:`TCC_IDX_LO];
    end
    if (WVALID && WREADY) begin
      n.w_got  = 1'b1;
      n.wdata  = WDATA[7:0];
      n.wstrb0 = WSTRB[0];
    end
    do_wr = s.aw_got && s.w_got;
    wr_en = do_wr && s.wstrb0 && idx_hit(s.awidx);
    if (do_wr) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = idx_hit(s.awidx) ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
    end
    if (s.bvalid && BREADY) begin
      n.bvalid = 1'b0;
    end
    wr_ctl[0] = wr_en && (s.awidx == `TCC_IDX_CTL0);
    wr_ctl[1] = wr_en && (s.awidx == `TCC_IDX_CTL1);
    wr_lo[0]  = wr_en && (s.awidx == `TCC_IDX_CH0_LO);
    wr_lo[1]  = wr_en && (s.awidx == `TCC_IDX_CH1_LO);
    wr_hi[0]  = wr_en && (s.awidx == `TCC_IDX_CH0_HI);
    wr_hi[1]  = wr_en && (s.awidx == `TCC_IDX_CH1_HI);

    // Matches of both channels, channel 1 pairs also look at channel 0
    match[0] = COUNT_TICK && (TIMER_COUNT == s.val[0]);
    match[1] = COUNT_TICK && (TIMER_COUNT == s.val[1]);

    for (int i = 0; i < 2; i++) begin
      // Capture source and edge detection; a select change may fake an edge
      src = s.ctl[i][`TCC_RADIO_BIT] ? RADIO_IRQ : s.sync2[i];
      n.prev[i] = src;
      rise = src && !s.prev[i];
      fall = !src && s.prev[i];
      cap_ev[i] = !s.ctl[i][`TCC_MODE_BIT] &&
                  ((s.ctl[i][`TCC_CAP_RISE] && rise) ||
                   (s.ctl[i][`TCC_CAP_FALL] && fall));
      cmp_ev[i] = s.ctl[i][`TCC_MODE_BIT] && match[i];
      if (cap_ev[i]) begin
        n.val[i] = TIMER_COUNT;
      end

      // Deferred compare value lands when the counter is at zero
      if (s.pend[i] && (TIMER_COUNT == `TCC_ZERO)) begin
        n.val[i]  = s.pendv[i];
        n.pend[i] = 1'b0;
      end

      // Output action, applied only in compare mode
      o = s.out[i];
      if (s.ctl[i][`TCC_MODE_BIT]) begin
        unique case (tcc_pkg::act_e'(s.ctl[i][`TCC_ACT_HI:`TCC_ACT_LO]))
          tcc_pkg::ACT_SET: if (match[i]) o = 1'b1;
          tcc_pkg::ACT_CLR: if (match[i]) o = 1'b0;
          tcc_pkg::ACT_TGL: if (match[i]) o = !s.out[i];
          tcc_pkg::ACT_UP_SET: begin
            if (i == 1 && ud) begin
              if (match[i]) o = !COUNT_DOWN;
            end else if (match[i]) begin
              o = 1'b1;
            end else if (zero) begin
              o = 1'b0;
            end
          end
          tcc_pkg::ACT_UP_CLR: begin
            if (i == 1 && ud) begin
              if (match[i]) o = COUNT_DOWN;
            end else if (match[i]) begin
              o = 1'b0;
            end else if (zero) begin
              o = 1'b1;
            end
          end
          tcc_pkg::ACT_PAIR_CLR: begin
            // Channel 0 leaves its output alone on reserved codes
            if (i == 1) begin
              if (match[1]) o = 1'b1;
              else if (match[0]) o = 1'b0;
            end
          end
          tcc_pkg::ACT_PAIR_SET: begin
            if (i == 1) begin
              if (match[1]) o = 1'b0;
              else if (match[0]) o = 1'b1;
            end
          end
          tcc_pkg::ACT_INIT: o = s.out[i];
        endcase
      end
      n.out[i] = o;

      // Register writes win over the running logic of the same cycle
      if (wr_ctl[i]) begin
        n.ctl[i] = s.wdata;
        if (tcc_pkg::act_e'(s.wdata[`TCC_ACT_HI:`TCC_ACT_LO]) ==
            tcc_pkg::ACT_INIT) begin
          n.ctl[i][`TCC_ACT_HI:`TCC_ACT_LO] =
            s.ctl[i][`TCC_ACT_HI:`TCC_ACT_LO];
          n.out[i] = `TCC_OUT_INIT;
        end
      end
      if (wr_lo[i]) begin
        n.lobuf[i] = s.wdata;
      end
      if (wr_hi[i]) begin
        if (s.ctl[i][`TCC_MODE_BIT]) begin
          n.pendv[i] = {s.wdata, s.lobuf[i]};
          n.pend[i]  = 1'b1;
        end else begin
          n.val[i]  = {s.wdata, s.lobuf[i]};
          n.pend[i] = 1'b0;
        end
      end
    end

    // Sticky flags: write one clears, a new event in that cycle wins
    n.stat = s.stat;
    if (wr_en && (s.awidx == `TCC_IDX_STAT)) begin
      n.stat = s.stat & ~s.wdata[1:0];
    end
    n.stat = n.stat | cap_ev | cmp_ev;
    if (wr_en && (s.awidx == `TCC_IDX_MASK)) begin
      n.mask = s.wdata[1:0];
    end

    // Read channel: one cycle to the answer, unmapped reads give an error
    if (s.rvalid && RREADY) begin
      n.rvalid = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      n.rvalid = 1'b1;
      n.rresp  = idx_hit(ridx) ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
      unique case (ridx)
        `TCC_IDX_CH0_LO: n.rdata = s.val[0][7:0];
        `TCC_IDX_CH0_HI: n.rdata = s.val[0][15:8];
        `TCC_IDX_CH1_LO: n.rdata = s.val[1][7:0];
        `TCC_IDX_CH1_HI: n.rdata = s.val[1][15:8];
        `TCC_IDX_CTL0:   n.rdata = s.ctl[0];
        `TCC_IDX_CTL1:   n.rdata = s.ctl[1];
        `TCC_IDX_STAT:   n.rdata = {6'h00, s.stat};
        `TCC_IDX_MASK:   n.rdata = {6'h00, s.mask};
        default:         n.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s <= ST_RST;
    end else begin
      s <= n;
    end
  end

  // Set action drives the output high one cycle after a match
  property p_set_on_match;
    @(posedge CLK) disable iff (!NRST)
    (cmp_ev[0] && !wr_ctl[0] &&
     s.ctl[0][`TCC_ACT_HI:`TCC_ACT_LO] == tcc_pkg::ACT_SET) |=> CMP_OUT[0];
  endproperty
  a_set_on_match: assert property (p_set_on_match)
    else $error("set action did not drive output high");
  property p_toggle;
    @(posedge CLK) disable iff (!NRST)
    (cmp_ev[1] && !wr_ctl[1] && s.ctl[1][`TCC_ACT_HI:`TCC_ACT_LO] ==
     tcc_pkg::ACT_TGL) |=> CMP_OUT[1] != $past(CMP_OUT[1]);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle action did not invert output");
  property p_pair_clr;
    @(posedge CLK) disable iff (!NRST)
    (CMP_OE[1] && match[0] && !match[1] && !wr_ctl[1] &&
     tcc_pkg::ACT_PAIR_CLR == s.ctl[1][`TCC_ACT_HI:`TCC_ACT_LO]) |=>
      !CMP_OUT[1];
  endproperty
  a_pair_clr: assert property (p_pair_clr)
    else $error("pair action did not clear on channel 0 match");
  property p_init_keeps_code;
    @(posedge CLK) disable iff (!NRST)
    (wr_ctl[0] && s.wdata[`TCC_ACT_HI:`TCC_ACT_LO] == tcc_pkg::ACT_INIT)
      |=> s.ctl[0][`TCC_ACT_HI:`TCC_ACT_LO] ==
          $past(s.ctl[0][`TCC_ACT_HI:`TCC_ACT_LO]) &&
          CMP_OUT[0] == `TCC_OUT_INIT;
  endproperty
  a_init_keeps_code: assert property (p_init_keeps_code)
    else $error("init write changed action field or missed output");
  property p_hi_deferred;
    @(posedge CLK) disable iff (!NRST)
    (wr_hi[0] && s.ctl[0][`TCC_MODE_BIT] && TIMER_COUNT != `TCC_ZERO)
      |=> s.val[0] == $past(s.val[0]);
  endproperty
  a_hi_deferred: assert property (p_hi_deferred)
    else $error("compare value changed before counter zero");
  property p_lo_buffered;
    @(posedge CLK) disable iff (!NRST)
    (wr_lo[1] && !cap_ev[1] && !s.pend[1]) |=> s.val[1] == $past(s.val[1]);
  endproperty
  a_lo_buffered: assert property (p_lo_buffered)
    else $error("low byte write reached value directly");
  property p_capture_load;
    @(posedge CLK) disable iff (!NRST)
    (cap_ev[0] && !wr_hi[0] && !s.pend[0])
      |=> s.val[0] == $past(TIMER_COUNT) && s.stat[0];
  endproperty
  a_capture_load: assert property (p_capture_load)
    else $error("capture did not load counter value");
  property p_no_capture;
    @(posedge CLK) disable iff (!NRST)
    (s.ctl[1][`TCC_CAP_FALL:`TCC_CAP_RISE] == 2'h0) |-> !cap_ev[1];
  endproperty
  a_no_capture: assert property (p_no_capture)
    else $error("capture occurred with edge field cleared");
  property p_flag_unmasked;
    @(posedge CLK) disable iff (!NRST)
    (cmp_ev[1] && !im[1]) |=> s.stat[1];
  endproperty
  a_flag_unmasked: assert property (p_flag_unmasked)
    else $error("event flag not set while interrupt disabled");
  property p_irq_gate;
    @(posedge CLK) disable iff (!NRST)
    IRQ |-> (s.stat[0] && s.mask[0] && im[0]) ||
            (s.stat[1] && s.mask[1] && im[1]);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt raised without an enabled flag");

endmodule : timer_channel_capture_compare

`default_nettype wire

// [design/tcc_defines.svh]
// Register indices, field positions, codes and reset values for the
// two-channel capture/compare block.
// Assumes an AXI4-Lite master that places each register in one aligned word.
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// Register indices, byte address is four times the index
`define TCC_IDX_CH0_LO   10'h0da
`define TCC_IDX_CH0_HI   10'h0db
`define TCC_IDX_CH1_LO   10'h0dc
`define TCC_IDX_CH1_HI   10'h0dd
`define TCC_IDX_CTL0     10'h0e5
`define TCC_IDX_CTL1     10'h0e6
`define TCC_IDX_STAT     10'h0f0
`define TCC_IDX_MASK     10'h0f1

// Address slice that carries the index
`define TCC_ADDR_W       12
`define TCC_IDX_HI       11
`define TCC_IDX_LO       2

// Control register fields
`define TCC_RADIO_BIT    7
`define TCC_IM_BIT       6
`define TCC_ACT_HI       5
`define TCC_ACT_LO       3
`define TCC_MODE_BIT     2
`define TCC_CAP_RISE     0
`define TCC_CAP_FALL     1

// Reset values
`define TCC_CTL_RST      8'h40
`define TCC_MASK_RST     2'h3
`define TCC_OUT_INIT     1'h0

// Counter facts
`define TCC_ZERO         16'h0000
`define TCC_MODE_UPDOWN  2'h3

// AXI responses
`define TCC_RESP_OKAY    2'h0
`define TCC_RESP_SLVERR  2'h2

`endif

// [design/tcc_pkg.sv]
// Types shared by the capture/compare block: action codes and the state.
// Assumes nothing beyond the defines header.
package tcc_pkg;

  // Compare output action codes
  typedef enum logic [2:0] {
    ACT_SET      = 3'h0,
    ACT_CLR      = 3'h1,
    ACT_TGL      = 3'h2,
    ACT_UP_SET   = 3'h3,
    ACT_UP_CLR   = 3'h4,
    ACT_PAIR_CLR = 3'h5,
    ACT_PAIR_SET = 3'h6,
    ACT_INIT     = 3'h7
  } act_e;

  // Whole state of the block
  typedef struct packed {
    logic [1:0][7:0]  ctl;
    logic [1:0][15:0] val;
    logic [1:0][7:0]  lobuf;
    logic [1:0][15:0] pendv;
    logic [1:0]       pend;
    logic [1:0]       out;
    logic [1:0]       sync1;
    logic [1:0]       sync2;
    logic [1:0]       prev;
    logic [1:0]       stat;
    logic [1:0]       mask;
    logic             aw_got;
    logic             w_got;
    logic [9:0]       awidx;
    logic [7:0]       wdata;
    logic             wstrb0;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [7:0]       rdata;
    logic [1:0]       rresp;
  } state_s;

endpackage : tcc_pkg

// [dv/tcc_pins.sv]
// Far-side model: capture pin source and compare pin observer.
// Assumes pin changes may land on a falling edge of clk, off sampling.
`timescale 1ns/1ns
`default_nettype none

module tcc_pins (
  // Clock
  input  wire logic       clk,
  // Compare pins from the block
  input  wire logic [1:0] cmp_out,
  input  wire logic [1:0] cmp_oe,
  // Capture pins to the block
  output logic [1:0]      cap_in,
  // Board level of the compare pins
  output logic [1:0]      pin_lvl
);
  // Undriven compare pins fall to the board pull-down
  assign pin_lvl = cmp_out & cmp_oe;

  // Pins start low so no edge is seen out of reset
  initial cap_in = 2'h0;

  // Edges land mid-cycle like a real pin; syncing is the block's job
  task automatic set_pin(input int ch, input logic v);
    @(negedge clk);
    cap_in[ch] = v;
  endtask : set_pin
endmodule : tcc_pins

`default_nettype wire

// [dv/timer_channel_capture_compare_test.sv]
// Self-checking bench for the two-channel capture/compare block.
// Assumes the block's AXI4-Lite slave and the counter view on one clock.
`include "tcc_defines.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", nm, (e), (s)); end end

module timer_channel_capture_compare_test;
  typedef struct {
    logic [2:0] a, b;
    logic [1:0] c;
    logic       u, d;
    logic [1:0] o;
  } row_s;
  logic        CLK, NRST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
  logic        COUNT_TICK, COUNT_DOWN, RADIO_IRQ;
  logic [11:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rd_d;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, COUNT_MODE, CAP_IN, CMP_OUT, CMP_OE;
  logic [1:0]  rd_r, wr_r, pin_lvl;
  logic [15:0] TIMER_COUNT, v16, expv;
  int          errors, check_count, e;
  // Counts by selector: zero, ch0 value, ch1 value, no match
  logic [15:0] cnt [4] = '{16'h0000, 16'h0020, 16'h0010, 16'h0005};
  logic [9:0]  ri [8] = '{`TCC_IDX_CTL0, `TCC_IDX_CTL1, `TCC_IDX_CH0_LO,
    `TCC_IDX_CH0_HI, `TCC_IDX_CH1_LO, `TCC_IDX_CH1_HI, `TCC_IDX_STAT,
    `TCC_IDX_MASK};
  logic [7:0]  rv [8] = '{8'h40, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h03};
  // ch0 code, ch1 code, count, up-down, down, outputs {ch1,ch0}
  row_s rows [25] = '{
    '{3'h0, 3'h1, 2'h1, 1'h0, 1'h0, 2'h1}, '{3'h1, 3'h0, 2'h2, 1'h0, 1'h0, 2'h3},
    '{3'h1, 3'h0, 2'h1, 1'h0, 1'h0, 2'h2}, '{3'h2, 3'h2, 2'h1, 1'h0, 1'h0, 2'h3},
    '{3'h2, 3'h2, 2'h2, 1'h0, 1'h0, 2'h1}, '{3'h2, 3'h2, 2'h1, 1'h0, 1'h0, 2'h0},
    '{3'h3, 3'h1, 2'h1, 1'h0, 1'h0, 2'h1}, '{3'h3, 3'h1, 2'h0, 1'h0, 1'h0, 2'h0},
    '{3'h4, 3'h3, 2'h1, 1'h0, 1'h0, 2'h0}, '{3'h4, 3'h3, 2'h2, 1'h0, 1'h0, 2'h2},
    '{3'h4, 3'h3, 2'h0, 1'h0, 1'h0, 2'h1}, '{3'h5, 3'h4, 2'h1, 1'h0, 1'h0, 2'h1},
    '{3'h5, 3'h4, 2'h2, 1'h0, 1'h0, 2'h1}, '{3'h5, 3'h4, 2'h0, 1'h0, 1'h0, 2'h3},
    '{3'h6, 3'h4, 2'h1, 1'h0, 1'h0, 2'h3}, '{3'h0, 3'h5, 2'h1, 1'h0, 1'h0, 2'h1},
    '{3'h0, 3'h5, 2'h2, 1'h0, 1'h0, 2'h3}, '{3'h0, 3'h6, 2'h2, 1'h0, 1'h0, 2'h1},
    '{3'h0, 3'h6, 2'h1, 1'h0, 1'h0, 2'h3}, '{3'h0, 3'h3, 2'h2, 1'h1, 1'h1, 2'h1},
    '{3'h0, 3'h3, 2'h2, 1'h1, 1'h0, 2'h3}, '{3'h0, 3'h3, 2'h0, 1'h1, 1'h1, 2'h3},
    '{3'h0, 3'h4, 2'h2, 1'h1, 1'h0, 2'h1}, '{3'h0, 3'h4, 2'h2, 1'h1, 1'h1, 2'h3},
    '{3'h7, 3'h7, 2'h3, 1'h0, 1'h0, 2'h0}};

  timer_channel_capture_compare DUT (
    .CLK(CLK), .NRST(NRST), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .TIMER_COUNT(TIMER_COUNT), .COUNT_TICK(COUNT_TICK),
    .COUNT_DOWN(COUNT_DOWN), .COUNT_MODE(COUNT_MODE), .CAP_IN(CAP_IN),
    .RADIO_IRQ(RADIO_IRQ), .CMP_OUT(CMP_OUT), .CMP_OE(CMP_OE), .IRQ(IRQ));

  tcc_pins pins (.clk(CLK), .cmp_out(CMP_OUT), .cmp_oe(CMP_OE),
    .cap_in(CAP_IN), .pin_lvl(pin_lvl));

  // 100 MHz clock
  initial CLK = 1'b0;
  always #5 CLK = ~CLK;

  // Verdict and end of run
  task automatic wrap_up();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // A handshake that never completes ends the run
  task automatic hang();
    errors++;
    $display("[ERR] handshake exp done got timeout");
    wrap_up();
  endtask : hang

  // Write one byte; each valid drops once its channel is taken
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic a, w;
    int   n;
    a = 0;
    w = 0;
    AWADDR <= {i, 2'h0};
    WDATA <= {24'h0, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge CLK);
      if (BVALID) break;
      if (!a && AWREADY) begin
        a = 1;
        AWVALID <= 1'b0;
      end
      if (!w && WREADY) begin
        w = 1;
        WVALID <= 1'b0;
      end
    end
    if (n == 40) hang();
    wr_r = BRESP;
  endtask : wr

  // Read one register; RREADY is held high throughout
  task automatic rd(input logic [9:0] i);
    logic t;
    int   n;
    t = 0;
    ARADDR <= {i, 2'h0};
    ARVALID <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge CLK);
      if (t && RVALID) break;
      if (!t && ARREADY) begin
        t = 1;
        ARVALID <= 1'b0;
      end
    end
    if (n == 40) hang();
    rd_d = RDATA;
    rd_r = RRESP;
  endtask : rd

  // Both bytes of a value, high first
  task automatic rd16(input logic [9:0] hi, input logic [9:0] lo);
    rd(hi);
    v16[15:8] = rd_d[7:0];
    rd(lo);
    v16[7:0] = rd_d[7:0];
  endtask : rd16

  // One counter step with its tick
  task automatic tk(input logic [15:0] c);
    TIMER_COUNT <= c;
    COUNT_TICK <= 1'b1;
    @(posedge CLK);
    COUNT_TICK <= 1'b0;
    @(posedge CLK);
  endtask : tk

  // Main sequence
  initial begin
    {NRST, AWVALID, WVALID, ARVALID, COUNT_TICK, COUNT_DOWN, RADIO_IRQ} <= '0;
    {BREADY, RREADY} <= 2'h3;
    {AWADDR, ARADDR, WDATA} <= '0;
    WSTRB <= 4'hf;
    TIMER_COUNT <= 16'h0005;
    COUNT_MODE <= 2'h1;
    repeat (6) @(posedge CLK);
    NRST <= 1'b1;
    // Values written in capture mode land at once
    wr(`TCC_IDX_CH0_LO, 8'h20);
    wr(`TCC_IDX_CH0_HI, 8'h00);
    wr(`TCC_IDX_CH1_LO, 8'h10);
    wr(`TCC_IDX_CH1_HI, 8'h00);
    foreach (rows[k]) begin
      wr(`TCC_IDX_CTL0, {2'h1, rows[k].a, 3'h4});
      wr(`TCC_IDX_CTL1, {2'h1, rows[k].b, 3'h4});
      COUNT_MODE <= rows[k].u ? `TCC_MODE_UPDOWN : 2'h1;
      COUNT_DOWN <= rows[k].d;
      tk(cnt[rows[k].c]);
      `CHK("cmp_out", rows[k].o, CMP_OUT)
      `CHK("pin", rows[k].o, pin_lvl)
    end
    rd(`TCC_IDX_CTL0);
    `CHK("ctl0", 8'h44, rd_d[7:0])
    rd(`TCC_IDX_CTL1);
    `CHK("ctl1", 8'h64, rd_d[7:0])
    rd(`TCC_IDX_STAT);
    `CHK("stat", 8'h03, rd_d[7:0])
    `CHK("irq", 1'b1, IRQ)
    wr(`TCC_IDX_CTL0, 8'h04);
    wr(`TCC_IDX_CTL1, 8'h04);
    `CHK("irq", 1'b0, IRQ)
    // A match while the enable bit is clear still raises its flag
    wr(`TCC_IDX_STAT, 8'h02);
    tk(16'h0010);
    `CHK("irq", 1'b0, IRQ)
    rd(`TCC_IDX_STAT);
    `CHK("stat", 8'h03, rd_d[7:0])
    wr(`TCC_IDX_CTL0, 8'h44);
    `CHK("irq", 1'b1, IRQ)
    wr(`TCC_IDX_MASK, 8'h00);
    `CHK("irq", 1'b0, IRQ)
    wr(`TCC_IDX_MASK, 8'h03);
    wr(`TCC_IDX_STAT, 8'h01);
    rd(`TCC_IDX_STAT);
    `CHK("stat", 8'h02, rd_d[7:0])
    `CHK("irq", 1'b0, IRQ)
    wr(`TCC_IDX_CTL1, 8'h44);
    `CHK("irq", 1'b1, IRQ)
    // Second reset in mid-run, then reset values
    NRST <= 1'b0;
    repeat (2) @(posedge CLK);
    `CHK("irq", 1'b0, IRQ)
    `CHK("oe", 2'h0, CMP_OE)
    NRST <= 1'b1;
    @(posedge CLK);
    for (int k = 0; k < 8; k++) begin
      rd(ri[k]);
      `CHK("reset", {24'h0, rv[k]}, rd_d)
      `CHK("rresp", `TCC_RESP_OKAY, rd_r)
    end
    // Compare-mode value update waits for a zero count
    wr(`TCC_IDX_CTL0, 8'h44);
    `CHK("bresp", `TCC_RESP_OKAY, wr_r)
    wr(`TCC_IDX_CH0_LO, 8'h34);
    wr(`TCC_IDX_CH0_HI, 8'h12);
    rd16(`TCC_IDX_CH0_HI, `TCC_IDX_CH0_LO);
    `CHK("held", 16'h0000, v16)
    tk(16'h0000);
    rd16(`TCC_IDX_CH0_HI, `TCC_IDX_CH0_LO);
    `CHK("landed", 16'h1234, v16)
    // Every edge selection on channel 1, rise then fall
    expv = 16'h0000;
    for (e = 0; e < 4; e++) begin
      wr(`TCC_IDX_CTL1, {6'h10, e[1:0]});
      TIMER_COUNT <= 16'h1100 + e[15:0];
      pins.set_pin(1, 1'b1);
      repeat (6) @(posedge CLK);
      TIMER_COUNT <= 16'h2200 + e[15:0];
      pins.set_pin(1, 1'b0);
      repeat (6) @(posedge CLK);
      expv = (e == 1) ? 16'h1101 : (e > 1) ? 16'h2200 + e[15:0] : expv;
      rd16(`TCC_IDX_CH1_HI, `TCC_IDX_CH1_LO);
      `CHK("capture", expv, v16)
    end
    // Radio select ignores the pin and takes the radio event
    wr(`TCC_IDX_CTL0, 8'hc1);
    TIMER_COUNT <= 16'h0333;
    pins.set_pin(0, 1'b1);
    repeat (6) @(posedge CLK);
    rd16(`TCC_IDX_CH0_HI, `TCC_IDX_CH0_LO);
    `CHK("pin ignored", 16'h1234, v16)
    TIMER_COUNT <= 16'h0777;
    RADIO_IRQ <= 1'b1;
    repeat (4) @(posedge CLK);
    rd16(`TCC_IDX_CH0_HI, `TCC_IDX_CH0_LO);
    `CHK("radio", 16'h0777, v16)
    // Unmapped places answer with an error
    rd(10'h3ff);
    `CHK("rresp", `TCC_RESP_SLVERR, rd_r)
    wr(10'h3fe, 8'h5a);
    `CHK("bresp", `TCC_RESP_SLVERR, wr_r)
    wrap_up();
  end
endmodule : timer_channel_capture_compare_test

`default_nettype wire
